// *** rtl/aisel_pkg.sv ***
// Package with register map, field layouts and encodings of the converter input select block.
package aisel_pkg;

    // Register byte addresses on the Wishbone bus.
    localparam logic [3:0] ADDR_INPUT_CLOCK = 4'h0;
    localparam logic [3:0] ADDR_REF_AMP     = 4'h4;
    localparam logic [3:0] ADDR_BANDGAP     = 4'h8;
    localparam logic [3:0] ADDR_CHANNEL     = 4'hC;

    // Field positions.
    localparam int SRC_LSB     = 4;
    localparam int AMP_EN_BIT  = 7;
    localparam int AMP_IN_BIT  = 4;
    localparam int REFSEL_LSB  = 2;
    localparam int BG_EN_BIT   = 0;
    localparam int DIV_LSB     = 0;
    localparam int GAIN_LSB    = 0;
    localparam int CHAN_LSB    = 0;

    // Writable masks; unimplemented bits are zero.
    localparam logic [7:0] MASK_INPUT_CLOCK = 8'hF7;
    localparam logic [7:0] MASK_REF_AMP     = 8'h9F;
    localparam logic [7:0] MASK_BANDGAP     = 8'h01;
    localparam logic [7:0] MASK_CHANNEL     = 8'h0F;
    localparam logic [7:0] RESET_VALUE      = 8'h00;

    // Converter input selections.
    typedef enum logic [3:0] {
        AISEL_IN_EXT    = 4'h0,
        AISEL_IN_AVDD   = 4'h1,
        AISEL_IN_AVDD2  = 4'h2,
        AISEL_IN_AVDD4  = 4'h3,
        AISEL_IN_VR     = 4'h4,
        AISEL_IN_VR2    = 4'h5,
        AISEL_IN_VR4    = 4'h6,
        AISEL_IN_GND    = 4'h7,
        AISEL_IN_NONE   = 4'hF
    } aisel_input_t;

    // Reference selections.
    typedef enum logic [1:0] {
        AISEL_REF_AVDD = 2'h0,
        AISEL_REF_PIN  = 2'h1,
        AISEL_REF_AMP  = 2'h2
    } aisel_ref_t;

    // Register file state.
    typedef struct packed {
        logic [7:0] input_clock;
        logic [7:0] ref_amp;
        logic [7:0] bandgap;
        logic [7:0] channel;
        logic       ack;
        logic [7:0] rdata;
        logic [6:0] div_cnt;
        logic       conv_clk;
        logic       amp_en;
        logic       amp_from_bandgap;
        logic       amp_pin_connect;
        logic [1:0] amp_gain;
        logic       bg_en;
        logic [1:0] ref_sel;
        logic       ref_pin_connect;
        logic [3:0] conv_input;
        logic       ext_enable;
        logic [15:0] ext_channel_onehot;
        logic [15:0] pin_block;
    } aisel_state_t;

endpackage : aisel_pkg

// *** rtl/aisel_top.sv ***
// Register file and analog switch control for converter input and reference selection.
// Operation
// - Codes 0000, 0100, 11xx route external channel
// - Codes 0001-0011 select supply, half, quarter
// - Codes 0101-0111 select amplifier output, scaled
// - Codes 10xx connect converter input to ground
// - Internal source disconnects all external channels
// - Code 0000 uses channel field alone
// - Conversion clock is system clock over 2^n, over 2 for n = 0
// - Input/clock register bit 3 reads zero
// - Bit 7 switches reference amplifier on
// - Amplifier register bits 6,5 read zero
// - Bit 4 picks pin or bandgap input
// - Bandgap input disconnects amplifier input pin
// - Reference field picks supply, pin, amplifier
// - Internal reference disconnects external reference pin
// - Gain field selects four amplifier gains
// - Bandgap register holds only enable bit
// - Analog pin drops its pull-high resistor
// - Analog pin overrides port direction
// - Channel codes map to channels, reserved ignored
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
module aisel_top (
    // System.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Pins assigned as analog inputs by the pin-share logic.
    input  wire logic [15:0] analog_pin_i,
    // Converter control.
    output logic             conv_clk_o,
    output logic [3:0]       conv_input_o,
    output logic             ext_enable_o,
    output logic [15:0]      ext_channel_onehot_o,
    output logic [1:0]       ref_sel_o,
    output logic             ref_pin_connect_o,
    // Reference amplifier and bandgap.
    output logic             amp_en_o,
    output logic             amp_from_bandgap_o,
    output logic             amp_pin_connect_o,
    output logic [1:0]       amp_gain_o,
    output logic             bg_en_o,
    // Pad overrides.
    output logic [15:0]      pull_high_block_o,
    output logic [15:0]      dir_input_force_o
);

    aisel_pkg::aisel_state_t state_r;
    aisel_pkg::aisel_state_t state_nxt;

    // Decoded image of cleared registers, so outputs agree with the fields during reset.
    localparam aisel_pkg::aisel_state_t RST_STATE = '{
        input_clock:        aisel_pkg::RESET_VALUE,
        ref_amp:            aisel_pkg::RESET_VALUE,
        bandgap:            aisel_pkg::RESET_VALUE,
        channel:            aisel_pkg::RESET_VALUE,
        ack:                1'b0,
        rdata:              aisel_pkg::RESET_VALUE,
        div_cnt:            7'h00,
        conv_clk:           1'b0,
        amp_en:             1'b0,
        amp_from_bandgap:   1'b0,
        amp_pin_connect:    1'b1,
        amp_gain:           2'h0,
        bg_en:              1'b0,
        ref_sel:            aisel_pkg::AISEL_REF_AVDD,
        ref_pin_connect:    1'b0,
        conv_input:         aisel_pkg::AISEL_IN_EXT,
        ext_enable:         1'b1,
        ext_channel_onehot: 16'h0001,
        pin_block:          16'h0000
    };

    // Maps a channel code to a one-hot channel, zero for reserved codes.
    function automatic logic [15:0] chan_decode(input logic [3:0] code);
        logic [15:0] onehot;
        onehot = 16'h0000;
        unique case (code)
            4'h0: onehot = 16'h0001;
            4'h1: onehot = 16'h0002;
            4'h2: onehot = 16'h0004;
            4'h3: onehot = 16'h0000;
            4'h4: onehot = 16'h0000;
            4'h5: onehot = 16'h0000;
            4'h6: onehot = 16'h0000;
            4'h7: onehot = 16'h0000;
            4'h8: onehot = 16'h0000;
            4'h9: onehot = 16'h0200;
            4'hA: onehot = 16'h0400;
            4'hB: onehot = 16'h0800;
            4'hC: onehot = 16'h0000;
            4'hD: onehot = 16'h2000;
            4'hE: onehot = 16'h4000;
            4'hF: onehot = 16'h8000;
        endcase
        return onehot;
    endfunction : chan_decode

    // Merges a write byte through the mask of implemented bits.
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] data,
                                           input logic [7:0] mask);
        return (old & ~mask) | (data & mask);
    endfunction : wr_byte

    // Maps an input-source code to the converter input selection.
    function automatic logic [3:0] src_decode(input logic [3:0] code);
        logic [3:0] sel;
        sel = aisel_pkg::AISEL_IN_GND;
        unique case (code)
            4'h0: sel = aisel_pkg::AISEL_IN_EXT;
            4'h1: sel = aisel_pkg::AISEL_IN_AVDD;
            4'h2: sel = aisel_pkg::AISEL_IN_AVDD2;
            4'h3: sel = aisel_pkg::AISEL_IN_AVDD4;
            4'h4: sel = aisel_pkg::AISEL_IN_EXT;
            4'h5: sel = aisel_pkg::AISEL_IN_VR;
            4'h6: sel = aisel_pkg::AISEL_IN_VR2;
            4'h7: sel = aisel_pkg::AISEL_IN_VR4;
            4'h8: sel = aisel_pkg::AISEL_IN_GND;
            4'h9: sel = aisel_pkg::AISEL_IN_GND;
            4'hA: sel = aisel_pkg::AISEL_IN_GND;
            4'hB: sel = aisel_pkg::AISEL_IN_GND;
            4'hC: sel = aisel_pkg::AISEL_IN_EXT;
            4'hD: sel = aisel_pkg::AISEL_IN_EXT;
            4'hE: sel = aisel_pkg::AISEL_IN_EXT;
            4'hF: sel = aisel_pkg::AISEL_IN_EXT;
        endcase
        return sel;
    endfunction : src_decode

    // Tells whether an input-source code closes the external channel path.
    function automatic logic ext_decode(input logic [3:0] code);
        logic on;
        on = 1'b0;
        unique case (code)
            4'h0: on = 1'b1;
            4'h1: on = 1'b0;
            4'h2: on = 1'b0;
            4'h3: on = 1'b0;
            4'h4: on = 1'b1;
            4'h5: on = 1'b0;
            4'h6: on = 1'b0;
            4'h7: on = 1'b0;
            4'h8: on = 1'b0;
            4'h9: on = 1'b0;
            4'hA: on = 1'b0;
            4'hB: on = 1'b0;
            4'hC: on = 1'b1;
            4'hD: on = 1'b1;
            4'hE: on = 1'b1;
            4'hF: on = 1'b1;
        endcase
        return on;
    endfunction : ext_decode

    // Last count of a half period of the conversion clock, in system clocks.
    function automatic logic [6:0] div_limit(input logic [2:0] sel);
        logic [6:0] lim;
        lim = 7'h00;
        unique case (sel)
            3'h0: lim = 7'h00;
            3'h1: lim = 7'h00;
            3'h2: lim = 7'h01;
            3'h3: lim = 7'h03;
            3'h4: lim = 7'h07;
            3'h5: lim = 7'h0F;
            3'h6: lim = 7'h1F;
            3'h7: lim = 7'h3F;
        endcase
        return lim;
    endfunction : div_limit

    // Maps the reference field to the reference source.
    function automatic logic [1:0] ref_decode(input logic [1:0] code);
        logic [1:0] sel;
        sel = aisel_pkg::AISEL_REF_AVDD;
        unique casez (code)
            2'b00: sel = aisel_pkg::AISEL_REF_AVDD;
            2'b01: sel = aisel_pkg::AISEL_REF_PIN;
            2'b1?: sel = aisel_pkg::AISEL_REF_AMP;
        endcase
        return sel;
    endfunction : ref_decode

    // Connects the external reference pin only while it is the chosen reference.
    function automatic logic ref_pin_gate(input logic [1:0] code);
        logic g;
        g = 1'b0;
        unique casez (code)
            2'b00: g = 1'b0;
            2'b01: g = 1'b1;
            2'b1?: g = 1'b0;
        endcase
        return g;
    endfunction : ref_pin_gate

    // Connects the amplifier input pin only while the bandgap is not the input.
    function automatic logic amp_pin_gate(input logic from_bandgap);
        logic g;
        g = 1'b1;
        unique case (from_bandgap)
            1'b0: g = 1'b1;
            1'b1: g = 1'b0;
        endcase
        return g;
    endfunction : amp_pin_gate

    // Passes the gain code to the amplifier trim; codes match gain steps one to one.
    function automatic logic [1:0] gain_decode(input logic [1:0] code);
        logic [1:0] g;
        g = 2'h0;
        unique case (code)
            2'h0: g = 2'h0;
            2'h1: g = 2'h1;
            2'h2: g = 2'h2;
            2'h3: g = 2'h3;
        endcase
        return g;
    endfunction : gain_decode

    // Read image of the addressed register; unimplemented bits read zero.
    function automatic logic [7:0] rd_mux(input logic [3:0]              adr,
                                          input aisel_pkg::aisel_state_t s);
        logic [7:0] rd;
        rd = aisel_pkg::RESET_VALUE;
        unique case (adr)
            aisel_pkg::ADDR_INPUT_CLOCK: begin
                rd = s.input_clock & aisel_pkg::MASK_INPUT_CLOCK;
            end
            aisel_pkg::ADDR_REF_AMP: begin
                rd = s.ref_amp & aisel_pkg::MASK_REF_AMP;
            end
            aisel_pkg::ADDR_BANDGAP: begin
                rd = s.bandgap & aisel_pkg::MASK_BANDGAP;
            end
            aisel_pkg::ADDR_CHANNEL: begin
                rd = s.channel & aisel_pkg::MASK_CHANNEL;
            end
            default: begin
                rd = aisel_pkg::RESET_VALUE;
            end
        endcase
        return rd;
    endfunction : rd_mux

    logic       bus_req;
    logic       wr_en;

    logic [3:0] src;
    logic [2:0] div_sel;
    logic [6:0] div_lim;
    logic [3:0] chan_code;
    logic [1:0] ref_code;
    logic [1:0] gain_code;
    logic       amp_on;
    logic       amp_bg;
    logic       bg_on;

    assign bus_req   = cyc_i & stb_i & ~state_r.ack;
    assign wr_en     = bus_req & we_i & sel_i[0];

    assign src       = state_r.input_clock[aisel_pkg::SRC_LSB +: 4];
    assign div_sel   = state_r.input_clock[aisel_pkg::DIV_LSB +: 3];
    assign div_lim   = div_limit(div_sel);
    assign chan_code = state_r.channel[aisel_pkg::CHAN_LSB +: 4];
    assign ref_code  = state_r.ref_amp[aisel_pkg::REFSEL_LSB +: 2];
    assign gain_code = state_r.ref_amp[aisel_pkg::GAIN_LSB +: 2];
    assign amp_on    = state_r.ref_amp[aisel_pkg::AMP_EN_BIT];
    assign amp_bg    = state_r.ref_amp[aisel_pkg::AMP_IN_BIT];
    assign bg_on     = state_r.bandgap[aisel_pkg::BG_EN_BIT];

    always_comb begin
        state_nxt     = state_r;
        state_nxt.ack = bus_req;

        // Register writes through the masks of implemented bits.
        if (wr_en) begin
            unique case (adr_i)
                aisel_pkg::ADDR_INPUT_CLOCK: begin
                    state_nxt.input_clock = wr_byte(state_r.input_clock, dat_i[7:0],
                                                    aisel_pkg::MASK_INPUT_CLOCK);
                end

                aisel_pkg::ADDR_REF_AMP: begin
                    state_nxt.ref_amp = wr_byte(state_r.ref_amp, dat_i[7:0],
                                                aisel_pkg::MASK_REF_AMP);
                end

                aisel_pkg::ADDR_BANDGAP: begin
                    state_nxt.bandgap = wr_byte(state_r.bandgap, dat_i[7:0],
                                                aisel_pkg::MASK_BANDGAP);
                end

                aisel_pkg::ADDR_CHANNEL: begin
                    state_nxt.channel = wr_byte(state_r.channel, dat_i[7:0],
                                                aisel_pkg::MASK_CHANNEL);
                end
                default: begin
                end
            endcase
        end

        // Read data stands with the acknowledge.
        state_nxt.rdata = rd_mux(adr_i, state_r);

        // Conversion clock toggles after each half period; code 0 gives the fastest form.
        if (state_r.div_cnt >= div_lim) begin
            state_nxt.div_cnt  = 7'h00;
            state_nxt.conv_clk = ~state_r.conv_clk;
        end else begin
            state_nxt.div_cnt  = state_r.div_cnt + 7'h01;
            state_nxt.conv_clk = state_r.conv_clk;
        end

        // Converter input selection.
        state_nxt.conv_input = src_decode(src);
        state_nxt.ext_enable = ext_decode(src);
        if (state_nxt.ext_enable) begin
            state_nxt.ext_channel_onehot = chan_decode(chan_code);
        end else begin
            state_nxt.ext_channel_onehot = 16'h0000;
        end

        // Reference amplifier and reference path.
        state_nxt.amp_en           = amp_on;
        state_nxt.amp_from_bandgap = amp_bg;
        state_nxt.amp_pin_connect  = amp_pin_gate(amp_bg);
        state_nxt.amp_gain         = gain_decode(gain_code);
        state_nxt.bg_en            = bg_on;
        state_nxt.ref_sel          = ref_decode(ref_code);
        state_nxt.ref_pin_connect  = ref_pin_gate(ref_code);

        // Pins assigned as analog inputs drop pull-high and direction settings.
        state_nxt.pin_block = analog_pin_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= RST_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign dat_o                = {24'h000000, state_r.rdata};
    assign ack_o                = state_r.ack;

    assign conv_clk_o           = state_r.conv_clk;
    assign conv_input_o         = state_r.conv_input;
    assign ext_enable_o         = state_r.ext_enable;
    assign ext_channel_onehot_o = state_r.ext_channel_onehot;
    assign ref_sel_o            = state_r.ref_sel;
    assign ref_pin_connect_o    = state_r.ref_pin_connect;

    assign amp_en_o             = state_r.amp_en;
    assign amp_from_bandgap_o   = state_r.amp_from_bandgap;
    assign amp_pin_connect_o    = state_r.amp_pin_connect;
    assign amp_gain_o           = state_r.amp_gain;
    assign bg_en_o              = state_r.bg_en;

    assign pull_high_block_o    = state_r.pin_block;
    assign dir_input_force_o    = state_r.pin_block;

endmodule : aisel_top

// *** tb/aisel_monitor.sv ***
// Checker of bus and select output relations for the input select block.
`timescale 1ns/1ns
module aisel_monitor (
    // System and bus.
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Select outputs.
    input wire logic [15:0] analog_pin_i,
    input wire logic [3:0]  conv_input_o,
    input wire logic        ext_enable_o,
    input wire logic [15:0] ext_channel_onehot_o,
    input wire logic [1:0]  ref_sel_o,
    input wire logic        ref_pin_connect_o,
    input wire logic        amp_from_bandgap_o,
    input wire logic        amp_pin_connect_o,
    input wire logic        bg_en_o,
    input wire logic [15:0] pull_high_block_o,
    input wire logic [15:0] dir_input_force_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_ok;
    assign rd_ok = ack_o && !we_i;
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ext_off: assert property (conv_input_o != 4'h0 |-> !ext_enable_o &&
        ext_channel_onehot_o == 16'h0) else $error("external path open on internal source");
    a_ext_on: assert property (conv_input_o == 4'h0 |-> ext_enable_o)
        else $error("external path closed");
    a_onehot_single: assert property ($onehot0(ext_channel_onehot_o))
        else $error("two channels joined");
    a_ref_pin_gate: assert property (ref_pin_connect_o == (ref_sel_o == 2'h1))
        else $error("reference pin gating wrong");
    a_ref_code_legal: assert property (ref_sel_o != 2'h3)
        else $error("reference code illegal");
    a_amp_pin_gate: assert property (amp_pin_connect_o == !amp_from_bandgap_o)
        else $error("amplifier pin gating wrong");
    a_pull_follow: assert property (!$past(rst_i) |->
        pull_high_block_o == $past(analog_pin_i)) else $error("pull-high block wrong");
    a_dir_follow: assert property (!$past(rst_i) |->
        dir_input_force_o == $past(analog_pin_i)) else $error("direction force wrong");
    a_bit3_zero: assert property (rd_ok && adr_i == 4'h0 |-> dat_o[3] == 1'b0)
        else $error("bit 3 not zero");
    a_amp_gap_zero: assert property (rd_ok && adr_i == 4'h4 |-> dat_o[6:5] == 2'h0)
        else $error("amplifier gap bits not zero");
    a_bg_upper_zero: assert property (rd_ok && adr_i == 4'h8 |-> dat_o[7:1] == 7'h00)
        else $error("bandgap upper bits not zero");
    cover property (ack_o && we_i);
    cover property (conv_input_o == 4'h7);
    cover property (amp_from_bandgap_o && bg_en_o);
endmodule : aisel_monitor
bind aisel_top aisel_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
    .analog_pin_i, .conv_input_o, .ext_enable_o, .ext_channel_onehot_o, .ref_sel_o,
    .ref_pin_connect_o, .amp_from_bandgap_o, .amp_pin_connect_o, .bg_en_o,
    .pull_high_block_o, .dir_input_force_o);

// *** tb/aisel_top_tb.sv ***
// Self-checking bench of the input select block.
`timescale 1ns/1ns
module aisel_top_tb;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, conv_clk_o, ext_enable_o;
    logic        amp_en_o, amp_from_bandgap_o, amp_pin_connect_o, bg_en_o, ref_pin_connect_o;
    logic [3:0]  adr_i, sel_i, conv_input_o;
    logic [1:0]  ref_sel_o, amp_gain_o;
    logic [31:0] dat_i, dat_o;
    logic [15:0] analog_pin_i, ext_channel_onehot_o, pull_high_block_o, dir_input_force_o;
    int          failures, checked, i, k, r, t0, per;
    logic        p, e;
    aisel_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .analog_pin_i, .conv_clk_o, .conv_input_o, .ext_enable_o, .ext_channel_onehot_o,
        .ref_sel_o, .ref_pin_connect_o, .amp_en_o, .amp_from_bandgap_o, .amp_pin_connect_o,
        .amp_gain_o, .bg_en_o, .pull_high_block_o, .dir_input_force_o);
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic close_out;
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checked++;
        if (g !== x) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            failures++;
            close_out();
        end
        q = dat_o[7:0];
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(a, 1'b1, d, q);
        repeat (2) @(negedge clk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        logic [7:0] q;
        bus(a, 1'b0, 8'h00, q);
        chk(16'(q), 16'(x));
    endtask : rd
    function automatic logic [3:0] src_exp(input logic [3:0] s);
        case (s) inside
            4'b0000, 4'b0100, 4'b11??: return 4'h0;
            4'b10??: return 4'h7;
            default: return s[2] ? s - 4'h1 : s;
        endcase
    endfunction : src_exp
    initial begin
        {failures, checked} = 0;
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, analog_pin_i} = {4'b1000, 8'h0F, 48'h0};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 4; i++) rd(4'(4 * i), 8'h00);
        rd(4'h2, 8'h00);
        wr(aisel_pkg::ADDR_INPUT_CLOCK, 8'hFF);
        rd(aisel_pkg::ADDR_INPUT_CLOCK, aisel_pkg::MASK_INPUT_CLOCK);
        wr(aisel_pkg::ADDR_REF_AMP, 8'hFF);
        rd(aisel_pkg::ADDR_REF_AMP, aisel_pkg::MASK_REF_AMP);
        wr(aisel_pkg::ADDR_BANDGAP, 8'hFF);
        rd(aisel_pkg::ADDR_BANDGAP, aisel_pkg::MASK_BANDGAP);
        chk(16'(bg_en_o), 16'h1);
        wr(aisel_pkg::ADDR_CHANNEL, 8'h09);
        for (i = 0; i < 16; i++) begin
            wr(aisel_pkg::ADDR_INPUT_CLOCK, {i[3:0], 4'h0});
            e = src_exp(i[3:0]) == 4'h0;
            chk(16'(conv_input_o), 16'(src_exp(i[3:0])));
            chk(16'(ext_enable_o), 16'(e));
            chk(ext_channel_onehot_o, e ? 16'h0200 : 16'h0);
        end
        wr(aisel_pkg::ADDR_INPUT_CLOCK, 8'h00);
        for (i = 0; i < 16; i++) begin
            wr(aisel_pkg::ADDR_CHANNEL, 8'(i));
            e = i <= 2 || (i >= 9 && i != 12);
            chk(ext_channel_onehot_o, e ? 16'(1 << i) : 16'h0);
        end
        for (i = 0; i < 8; i++) begin
            wr(aisel_pkg::ADDR_REF_AMP, {i[2], 2'b00, i[0], i[1:0], i[1:0]});
            chk(16'({amp_en_o, amp_from_bandgap_o, amp_gain_o}), 16'({i[2], i[0], i[1:0]}));
            chk(16'(amp_pin_connect_o), 16'(!i[0]));
            chk(16'(ref_sel_o), i[1] ? 16'h2 : 16'(i[1:0]));
            chk(16'(ref_pin_connect_o), 16'(i[1:0] == 2'b01));
        end
        for (i = 0; i < 8; i++) begin
            wr(aisel_pkg::ADDR_INPUT_CLOCK, 8'(i));
            {p, r, t0, per} = 0;
            for (k = 0; k < 900 && r < 3; k++) begin
                @(negedge clk_i);
                if (conv_clk_o === 1'b1 && !p) begin
                    r++;
                    if (r == 3) per = k - t0;
                    t0 = k;
                end
                p = conv_clk_o;
            end
            chk(16'(per), (i == 0) ? 16'h0002 : 16'(1 << i));
        end
        @(posedge clk_i);
        analog_pin_i <= 16'hA5C3;
        repeat (3) @(negedge clk_i);
        chk(pull_high_block_o, 16'hA5C3);
        chk(dir_input_force_o, 16'hA5C3);
        close_out();
    end
endmodule : aisel_top_tb
